// File: design/sasp_pkg.sv
// Shared constants for the step attenuator serial port: word layout,
// reset values and the timing counts used by the host end.
// Assumes a 250 MHz system clock (4 ns) on both ends.
package sasp_pkg;

  // Control word layout, in shift order from bit 0 upward
  localparam int SASP_WORD_W = 8;
  localparam int SASP_RSV_W = 2;
  localparam int SASP_ATTN_W = 6;
  localparam int SASP_RSV_POS = 0;
  localparam int SASP_ATTN_POS = 2;
  localparam int SASP_ECHO_DELAY = 8;

  // Reset values: all zero selects maximum attenuation
  localparam logic [7:0] SASP_WORD_RESET = 8'h00;
  localparam logic [5:0] SASP_ATTN_RESET = 6'h00;
  localparam logic [1:0] SASP_RSV_RESET = 2'h0;

  // System clock period
  localparam int SASP_CLK_PERIOD_NS = 4;

  // Least reset release to first serial activity
  localparam int SASP_RST_SETUP_NS = 20;
  localparam int SASP_RST_SETUP_CYC = (SASP_RST_SETUP_NS + SASP_CLK_PERIOD_NS - 1)
                                      / SASP_CLK_PERIOD_NS;
  // Least serial data hold after the last clock edge
  localparam int SASP_HOLD_NS = 5;
  localparam int SASP_HOLD_CYC = (SASP_HOLD_NS + SASP_CLK_PERIOD_NS - 1)
                                 / SASP_CLK_PERIOD_NS;
  // Least chip select setup before the first clock edge
  localparam int SASP_CS_SETUP_NS = 40;
  localparam int SASP_CS_SETUP_CYC = (SASP_CS_SETUP_NS + SASP_CLK_PERIOD_NS - 1)
                                     / SASP_CLK_PERIOD_NS;

  // Reset pulse width and serial clock half period, in system clocks
  localparam int SASP_RST_PULSE_CYC = 8;
  localparam int SASP_SCLK_HALF_CYC = 8;

endpackage

// File: design/sasp_if.sv
// Five-wire serial link between the attenuator and its host.
// The bench instances one per device; chains are wired in the bench.
`timescale 1ns/1ps
interface sasp_if;
  logic serial_clk;
  logic chip_select_n;
  logic reset_n_pin;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  wire serial_out_seen;

  // A quiet output reads as low on the wire
  assign serial_out_seen = serial_out_oe & serial_out;

  modport dev (
    input serial_clk,
    input chip_select_n,
    input reset_n_pin,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output serial_clk,
    output chip_select_n,
    output reset_n_pin,
    output serial_in,
    input serial_out_seen
  );
endinterface

// File: design/sasp_host.sv
// Host end of the attenuator serial link: makes the serial clock by a
// divider, sends chained control words and returns the echoed words.
// Assumes one system clock and a synchronous active low reset.
`timescale 1ns/1ps
module sasp_host
  import sasp_pkg::*;
#(
  parameter int NUM_DEV = 1,
  parameter int HALF_CYC = SASP_SCLK_HALF_CYC,
  parameter int RST_PULSE_CYC = SASP_RST_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic reset_req_i,
  input wire logic [NUM_DEV*SASP_WORD_W-1:0] word_i,
  output logic busy_o,
  output logic done_o,
  output logic [NUM_DEV*SASP_WORD_W-1:0] echo_o,
  sasp_if.host lnk
);
  localparam int CHAIN_W = NUM_DEV * SASP_WORD_W;
  localparam int CNT_W = 8;
  localparam int PH_W = $clog2(2 * HALF_CYC);
  localparam int BIT_W = $clog2(CHAIN_W + 1);
  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] RSETUP_LAST = CNT_W'(SASP_RST_SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SASP_CS_SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(SASP_HOLD_CYC - 1);
  localparam logic [PH_W-1:0] PH_RISE = PH_W'(HALF_CYC - 1);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * HALF_CYC - 1);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(CHAIN_W - 1);

  // Refuse settings the echo sampling or the wait counter cannot serve
  if (HALF_CYC < 3 || NUM_DEV < 1 || RST_PULSE_CYC < 1 || RST_PULSE_CYC > 255) begin : g_bad
    $error("sasp_host: unsupported parameter value");
  end

  typedef enum logic [2:0] {H_RESET, H_RSETUP, H_IDLE, H_SETUP, H_SHIFT, H_HOLD} sasp_hstate_t;

  sasp_hstate_t state;
  logic [CNT_W-1:0] wait_cnt;
  logic [PH_W-1:0] ph;
  logic [BIT_W-1:0] bit_cnt;
  logic [CHAIN_W-1:0] tx;
  logic [CHAIN_W-1:0] rx;
  logic sclk;
  logic cs_n;
  logic rst_n;
  logic [1:0] so_sync;

  // Pin drive and handshake
  assign lnk.serial_clk = sclk;
  assign lnk.chip_select_n = cs_n;
  assign lnk.reset_n_pin = rst_n;
  assign lnk.serial_in = tx[0];
  assign busy_o = (state != H_IDLE);

  // Echo from the far end of the chain crosses two flops
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      so_sync <= 2'h0;
    end else begin
      so_sync <= {so_sync[0], lnk.serial_out_seen};
    end
  end

  // Frame sequencer; chip select idles high between frames
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= H_RESET;
      wait_cnt <= '0;
      ph <= '0;
      bit_cnt <= '0;
      tx <= '0;
      rx <= '0;
      echo_o <= '0;
      done_o <= 1'b0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      rst_n <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        H_RESET: begin
          if (wait_cnt == RST_LAST) begin
            wait_cnt <= '0;
            rst_n <= 1'b1;
            state <= H_RSETUP;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        H_RSETUP: begin
          if (wait_cnt == RSETUP_LAST) begin
            wait_cnt <= '0;
            done_o <= 1'b1;
            state <= H_IDLE;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        H_IDLE: begin
          if (reset_req_i) begin
            rst_n <= 1'b0;
            state <= H_RESET;
          end else if (start_i) begin
            tx <= word_i;
            cs_n <= 1'b0;
            state <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (wait_cnt == SETUP_LAST) begin
            wait_cnt <= '0;
            ph <= '0;
            state <= H_SHIFT;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        H_SHIFT: begin
          if (ph == PH_RISE) begin
            sclk <= 1'b1;
            rx <= {so_sync[1], rx[CHAIN_W-1:1]};
            ph <= ph + 1'b1;
          end else if (ph == PH_LAST) begin
            sclk <= 1'b0;
            ph <= '0;
            tx <= {1'b0, tx[CHAIN_W-1:1]};
            if (bit_cnt == BIT_LAST) begin
              bit_cnt <= '0;
              state <= H_HOLD;
            end else begin
              bit_cnt <= bit_cnt + 1'b1;
            end
          end else begin
            ph <= ph + 1'b1;
          end
        end
        H_HOLD: begin
          if (wait_cnt == HOLD_LAST) begin
            wait_cnt <= '0;
            cs_n <= 1'b1;
            echo_o <= rx;
            done_o <= 1'b1;
            state <= H_IDLE;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// File: design/sasp_device.sv
// Attenuator end of the serial link: shift register on the link clock,
// active attenuation register on the system clock.
// Assumes the host stops the serial clock while chip select is high and
// keeps chip select steady around serial clock edges.
// Assumes the reset pin is pulsed low at start-up, since the shift
// register has no system reset of its own.
// Assumes the host holds chip select high for a few system clocks after
// a frame, so the load sees a settled word.
//
// What this block does
// - Control word enters least significant bit first
// - Reset pin clears the shift register
// - Reset then chip select applies maximum attenuation
// - Chip select high blocks clock and data
// - Host idles chip select high
// - Output echoes input eight clocks later
// - Output quiet while chip select high
// - Host chains devices, eight bits each
// - Power-up loads all-zero control word
// - One removes a step, zero inserts it
// - Two reserved bits, then attenuation bits 0-5
// - Host waits after reset before shifting
// - Chip select rise loads active register
// - Reset pin fall zeroes active attenuation
`timescale 1ns/1ps
module sasp_device
  import sasp_pkg::*;
#(
  parameter int WORD_W = SASP_WORD_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  sasp_if.dev lnk,
  output logic [SASP_ATTN_W-1:0] attn_o,
  output logic [SASP_ATTN_W-1:0] step_in_o,
  output logic [SASP_RSV_W-1:0] reserved_o,
  output logic update_o,
  output logic reset_seen_o
);

  // The word must hold exactly the reserved and attenuation fields,
  // and its length sets the echo delay seen at the serial output
  if (WORD_W != SASP_RSV_W + SASP_ATTN_W || WORD_W != SASP_ECHO_DELAY) begin : g_bad
    $error("sasp_device: word width does not match the control word layout");
  end

  // ------------------------------------------------------------------
  // Link clock domain
  // ------------------------------------------------------------------

  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] next_shift_word;
  logic shift_en;

  // New bit enters at the top, the oldest bit walks toward bit 0
  assign next_shift_word = {lnk.serial_in, shift_word[WORD_W-1:1]};

  // Chip select gates the clock so idle bus noise shifts nothing
  assign shift_en = ~lnk.chip_select_n;

  // Shift register; the reset pin clears it even with the clock stopped
  always_ff @(posedge lnk.serial_clk or negedge lnk.reset_n_pin) begin
    if (!lnk.reset_n_pin) begin
      shift_word <= SASP_WORD_RESET;
    end else if (shift_en) begin
      shift_word <= next_shift_word;
    end
  end

  // Bit 0 is the bit that entered seven edges ago; it feeds the next
  // device of a chain, which samples it on the following edge
  assign lnk.serial_out = shift_word[0] & shift_en;
  assign lnk.serial_out_oe = shift_en;

  // ------------------------------------------------------------------
  // System clock domain
  // ------------------------------------------------------------------

  // Synchronisers: bit 0 feeds bit 1 only, bit 2 is the edge history
  logic [2:0] cs_sync;
  logic [2:0] rst_sync;
  logic cs_rise;
  logic rst_fall;
  logic rst_low;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cs_sync <= 3'h7;
      rst_sync <= 3'h7;
    end else begin
      cs_sync <= {cs_sync[1:0], lnk.chip_select_n};
      rst_sync <= {rst_sync[1:0], lnk.reset_n_pin};
    end
  end

  // Edge and level decode of the synchronised pins
  assign cs_rise = cs_sync[1] & ~cs_sync[2];
  assign rst_fall = ~rst_sync[1] & rst_sync[2];
  assign rst_low = ~rst_sync[1];

  // Reset pin outranks a load for as long as it is low
  logic force_max;
  logic take_word;

  assign force_max = rst_fall | rst_low;
  assign take_word = cs_rise & ~force_max;

  // Field slices of the shifted word. The word is steady by the time
  // the synchronised rise is seen, since the link clock is stopped
  // while chip select is high.
  logic [SASP_ATTN_W-1:0] word_attn;
  logic [SASP_RSV_W-1:0] word_rsv;

  assign word_attn = shift_word[SASP_ATTN_POS +: SASP_ATTN_W];
  assign word_rsv = shift_word[SASP_RSV_POS +: SASP_RSV_W];

  // Active attenuation register; the reset pin outranks a load
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      attn_o <= SASP_ATTN_RESET;
      reserved_o <= SASP_RSV_RESET;
    end else if (force_max) begin
      attn_o <= SASP_ATTN_RESET;
      reserved_o <= SASP_RSV_RESET;
    end else if (take_word) begin
      attn_o <= word_attn;
      reserved_o <= word_rsv;
    end
  end

  // Step drive, one flop per attenuation bit: a one bypasses its step,
  // a zero switches it in, so every reset switches all steps in
  logic [SASP_ATTN_W-1:0] step_rst;
  logic [SASP_ATTN_W-1:0] step_word;

  assign step_rst = ~SASP_ATTN_RESET;
  assign step_word = ~word_attn;

  for (genvar b = 0; b < SASP_ATTN_W; b++) begin : g_step
    // Each step flop follows the same priority as the active register
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        step_in_o[b] <= step_rst[b];
      end else if (force_max) begin
        step_in_o[b] <= step_rst[b];
      end else if (take_word) begin
        step_in_o[b] <= step_word[b];
      end
    end
  end

  // Status pulses for the user side
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      update_o <= 1'b0;
      reset_seen_o <= 1'b0;
    end else begin
      update_o <= take_word;
      reset_seen_o <= rst_fall;
    end
  end

endmodule

// File: bench/sasp_monitor.sv
// Checker for the attenuator serial link and the device's attenuation outputs.
// Assumes it watches one host and one device joined by one sasp_if.
`timescale 1ns/1ps
module sasp_monitor
  import sasp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic reset_n_pin,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic serial_out_seen,
  input wire logic [SASP_ATTN_W-1:0] attn_o,
  input wire logic [SASP_ATTN_W-1:0] step_in_o,
  input wire logic update_o,
  input wire logic reset_seen_o
);
  logic [3:0] rise_cnt;

  // Rises since the reset pin cleared the shift register, saturating at eight
  always_ff @(posedge serial_clk or negedge reset_n_pin) begin
    if (!reset_n_pin) begin
      rise_cnt <= 4'h0;
    end else if (!chip_select_n && rise_cnt < 4'h8) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  // Load steps: select released, then the active register takes the word
  sequence s_cs_rise;
    $rose(chip_select_n) && reset_n_pin;
  endsequence
  sequence s_loaded;
    ##[1:4] update_o;
  endsequence

  a_echo_eight_late: assert property (@(posedge serial_clk) disable iff (!reset_n_pin)
    !chip_select_n |-> serial_out == (rise_cnt >= 4'h8 ? $past(serial_in, 8) : 1'b0))
    else $error("serial output is not the input eight rises late");
  a_quiet_when_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    chip_select_n |-> !serial_out_oe && !serial_out_seen)
    else $error("serial output driven while deselected");
  a_load_on_rise: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_cs_rise |-> s_loaded)
    else $error("no load after select release");
  a_reset_zeroes_attn: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(reset_n_pin) |-> ##[1:5] (attn_o == 6'h00))
    else $error("reset pin did not zero attenuation");
  a_attn_has_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(attn_o) |-> update_o || reset_seen_o)
    else $error("attenuation changed without load or reset");
  a_step_inverse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    step_in_o == ~attn_o)
    else $error("step outputs not inverse of attenuation bits");
  a_clock_held_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    chip_select_n && $past(chip_select_n) |-> !$rose(serial_clk))
    else $error("serial clock ran while deselected");
  a_setup_after_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(reset_n_pin) |-> chip_select_n [*5])
    else $error("transfer began too soon after reset pin release");
endmodule

// File: bench/test_step_attenuator_serial_port.sv
// Self-checking bench: host and device joined by one link, host command port driven.
// Assumes the design files compiled before it; link clock made by the host.
`timescale 1ns/1ps
module test_step_attenuator_serial_port;
  import sasp_pkg::*;
  typedef struct packed {logic [7:0] word; logic [5:0] attn; logic [1:0] rsv;} sasp_row_t;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic start_i = 1'b0;
  logic reset_req_i = 1'b0;
  logic [7:0] word_i = 8'h00;
  logic busy_o, done_o, update_o, reset_seen_o;
  logic [7:0] echo_o;
  logic [7:0] prev;
  logic [5:0] attn_o, step_in_o;
  logic [1:0] reserved_o;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  sasp_row_t rows [5] = '{'{8'hfc, 6'h3f, 2'h0}, '{8'h01, 6'h00, 2'h1}, '{8'h06, 6'h01, 2'h2},
                          '{8'h80, 6'h20, 2'h0}, '{8'ha7, 6'h29, 2'h3}};

  sasp_if lnk_if ();
  sasp_host #(.NUM_DEV(1), .HALF_CYC(3), .RST_PULSE_CYC(2)) sasp_host_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .reset_req_i(reset_req_i),
    .word_i(word_i), .busy_o(busy_o), .done_o(done_o), .echo_o(echo_o), .lnk(lnk_if));
  sasp_device sasp_device_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .lnk(lnk_if), .attn_o(attn_o), .step_in_o(step_in_o),
    .reserved_o(reserved_o), .update_o(update_o), .reset_seen_o(reset_seen_o));
  sasp_monitor sasp_monitor_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .serial_clk(lnk_if.serial_clk),
    .chip_select_n(lnk_if.chip_select_n), .reset_n_pin(lnk_if.reset_n_pin),
    .serial_in(lnk_if.serial_in), .serial_out(lnk_if.serial_out),
    .serial_out_oe(lnk_if.serial_out_oe), .serial_out_seen(lnk_if.serial_out_seen),
    .attn_o(attn_o), .step_in_o(step_in_o), .update_o(update_o), .reset_seen_o(reset_seen_o));

  // System clock, 4 ns
  always #2 clk_i = ~clk_i;

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check_attn(input string name, input logic [5:0] exp, input logic [5:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_word(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One command: wait idle, raise request until taken, wait for done, let the load land
  task automatic run(input logic rst, input logic [7:0] w);
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    word_i = w;
    start_i = !rst;
    reset_req_i = rst;
    while (busy_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    start_i = 1'b0;
    reset_req_i = 1'b0;
    while (done_o !== 1'b1 && n < 500) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 500) mismatches++;
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    check_attn("attn after power-up", 6'h00, attn_o);
    prev = 8'h00;
    foreach (rows[i]) begin
      run(1'b0, rows[i].word);
      check_attn("attn", rows[i].attn, attn_o);
      check_attn("step_in", ~rows[i].attn, step_in_o);
      check_word("reserved", {6'h00, rows[i].rsv}, {6'h00, reserved_o});
      check_word("echo", prev, echo_o);
      prev = rows[i].word;
    end
    // Reset pin pulse in mid-run, then a word
    run(1'b1, 8'h00);
    check_attn("attn after reset pin", 6'h00, attn_o);
    check_attn("step_in after reset pin", 6'h3f, step_in_o);
    run(1'b0, 8'h5a);
    check_word("echo after reset pin", 8'h00, echo_o);
    check_attn("attn after reset pin word", 6'h16, attn_o);
    // Second power-up reset in mid-run
    rstn_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    check_attn("attn after second power-up", 6'h00, attn_o);
    run(1'b0, 8'hfc);
    check_word("echo after second power-up", 8'h00, echo_o);
    finish_test();
  end
endmodule
